// ===== verilog/brap_params.svh
// Constants for the burst read address pointer
`ifndef BRAP_PARAMS_SVH
`define BRAP_PARAMS_SVH
`define BRAP_ADDR_STATUS 8'h00
`define BRAP_ADDR_PTR_RESET 8'h00
`define BRAP_ADDR_WALK_FIRST 8'h68
`define BRAP_ADDR_WALK_LAST 8'h78
`define BRAP_ADDR_RESERVED 8'h79
`define BRAP_FMODE_OFF 2'h0
`define BRAP_STATUS_RESET 8'h00
`endif

// ===== verilog/brap_pkg.sv
// Types for the burst read address pointer
package brap_pkg;
    typedef enum logic [1:0] {
        brap_idle,
        brap_wait_addr,
        brap_single,
        brap_burst
    } brap_state_t;

    typedef struct packed {
        brap_state_t state;
        logic [7:0] ptr;
        logic [7:0] rdata;
        logic rvalid;
        logic spi_q1;
        logic spi_q2;
    } brap_regs_t;
endpackage : brap_pkg

// ===== verilog/brap_status_mux.sv
// Status alias view selection
`timescale 1ns/1ns
`include "brap_params.svh"
module brap_status_mux (
    // Mode
    input wire logic [1:0] fifo_mode,
    // Views
    input wire logic [7:0] sample_ready_flags,
    input wire logic [7:0] fifo_flags,
    // Result
    output logic [7:0] status_view
);
    // Any non-zero mode shows the FIFO view
    assign status_view = (fifo_mode == `BRAP_FMODE_OFF) ?
        sample_ready_flags : fifo_flags; // [R4]
endmodule : brap_status_mux

// ===== verilog/brap_pointer.sv
// Register address pointer with auto increment and status alias
//
// Contract
// R1 - The pointer steps only while a burst read is under way, never on a single access.
// R2 - In I2C mode a stop condition returns the pointer to 0x00.
// R3 - In SPI mode the pointer is not reset between transactions; the host sends a start address.
// R4 - Reads of 0x00 give the sample ready flags when FIFO mode is 0b00, else the FIFO flags.
// R5 - A burst may start at the status alias and run on into sample or FIFO data.
// R6 - From 0x68 through 0x78 each burst step moves to the next address; 0x79 has no successor.
// R7 - The host writes the start address first and the pointer loads it before the first byte.
`timescale 1ns/1ns
`include "brap_params.svh"
module brap_pointer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Interface select pin
    input wire logic spi_mode,
    // Serial front end events
    input wire logic xfer_start,
    input wire logic addr_valid,
    input wire logic [7:0] addr_byte,
    input wire logic burst_read,
    input wire logic byte_req,
    input wire logic stop_cond,
    input wire logic xfer_end,
    // FIFO mode and views
    input wire logic [1:0] fifo_mode,
    input wire logic [7:0] sample_ready_flags,
    input wire logic [7:0] fifo_flags,
    // Register file read port
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    // Read data
    output logic [7:0] read_data,
    output logic read_valid,
    output logic [7:0] ptr_addr,
    output logic burst_active
);
    brap_pkg::brap_regs_t cur;
    brap_pkg::brap_regs_t nxt;
    logic [7:0] status_view;
    logic spi_sync;

    brap_status_mux u_status (
        .fifo_mode(fifo_mode),
        .sample_ready_flags(sample_ready_flags),
        .fifo_flags(fifo_flags),
        .status_view(status_view)
    );

    // Successor of an address; the reserved slot holds still
    function automatic logic [7:0] brap_next(input logic [7:0] a);
        if (a == `BRAP_ADDR_RESERVED) begin
            brap_next = a; // [R6]
        end else begin
            brap_next = a + 8'h01; // [R6]
        end
    endfunction : brap_next

    assign spi_sync = cur.spi_q2;
    assign reg_addr = cur.ptr;
    assign ptr_addr = cur.ptr;
    assign read_data = cur.rdata;
    assign read_valid = cur.rvalid;
    assign burst_active = (cur.state == brap_pkg::brap_burst);

    always_comb begin
        nxt = cur;
        nxt.spi_q1 = spi_mode;
        nxt.spi_q2 = cur.spi_q1;
        nxt.rvalid = 1'b0;
        case (cur.state)
            brap_pkg::brap_idle: begin
                if (xfer_start) begin
                    nxt.state = brap_pkg::brap_wait_addr;
                end
            end
            brap_pkg::brap_wait_addr: begin
                if (addr_valid) begin
                    nxt.ptr = addr_byte; // [R7] [R3]
                    nxt.state = burst_read ? brap_pkg::brap_burst : brap_pkg::brap_single;
                end
            end
            brap_pkg::brap_single, brap_pkg::brap_burst: begin
                if (byte_req) begin
                    // Alias read of 0x00 lets one burst cover status then data
                    nxt.rdata = (cur.ptr == `BRAP_ADDR_STATUS) ?
                        status_view : reg_rdata; // [R4] [R5]
                    nxt.rvalid = 1'b1;
                    if (cur.state == brap_pkg::brap_burst) begin
                        nxt.ptr = brap_next(cur.ptr); // [R1] [R5] [R6]
                    end
                end
            end
            default: begin
                nxt.state = brap_pkg::brap_idle;
            end
        endcase
        if (xfer_end) begin
            nxt.state = brap_pkg::brap_idle;
        end
        // SPI has no stop, so the pointer keeps its place
        if (stop_cond && !spi_sync) begin
            nxt.ptr = `BRAP_ADDR_PTR_RESET; // [R2] [R3]
            nxt.state = brap_pkg::brap_idle;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur.state <= brap_pkg::brap_idle;
            cur.ptr <= `BRAP_ADDR_PTR_RESET;
            cur.rdata <= `BRAP_STATUS_RESET;
            cur.rvalid <= 1'b0;
            cur.spi_q1 <= 1'b0;
            cur.spi_q2 <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    property p_single_hold; // [R1]
        @(posedge sys_clk) disable iff (reset)
        (cur.state == brap_pkg::brap_single && byte_req && !stop_cond && !addr_valid)
            |=> ptr_addr == $past(ptr_addr);
    endproperty
    a_single_hold: assert property (p_single_hold) else $error("single read stepped pointer"); // [R1]

    property p_i2c_stop; // [R2]
        @(posedge sys_clk) disable iff (reset)
        (stop_cond && !spi_sync) |=> ptr_addr == 8'h00 && !burst_active;
    endproperty
    a_i2c_stop: assert property (p_i2c_stop) else $error("stop did not clear pointer"); // [R2]

    property p_spi_keep; // [R3]
        @(posedge sys_clk) disable iff (reset)
        (stop_cond && spi_sync && cur.state == brap_pkg::brap_idle)
            |=> ptr_addr == $past(ptr_addr);
    endproperty
    a_spi_keep: assert property (p_spi_keep) else $error("spi pointer was reset"); // [R3]

    property p_alias; // [R4]
        @(posedge sys_clk) disable iff (reset)
        (byte_req && ptr_addr == 8'h00 && !stop_cond && !xfer_end &&
         (cur.state == brap_pkg::brap_burst || cur.state == brap_pkg::brap_single))
            |=> read_valid && read_data ==
                ($past(fifo_mode) == 2'h0 ? $past(sample_ready_flags) : $past(fifo_flags));
    endproperty
    a_alias: assert property (p_alias) else $error("wrong status view"); // [R4]

    sequence s_burst_step;
        burst_active && byte_req && !stop_cond && !xfer_end &&
            ptr_addr >= 8'h68 && ptr_addr <= 8'h78;
    endsequence
    property p_walk; // [R6]
        @(posedge sys_clk) disable iff (reset)
        s_burst_step |=> ptr_addr == $past(ptr_addr) + 8'h01;
    endproperty
    a_walk: assert property (p_walk) else $error("burst did not step"); // [R6]

    property p_status_step; // [R5]
        @(posedge sys_clk) disable iff (reset)
        (burst_active && byte_req && !stop_cond && !xfer_end && ptr_addr == 8'h00)
            |=> ptr_addr == 8'h01 && read_valid;
    endproperty
    a_status_step: assert property (p_status_step) else $error("alias did not lead on"); // [R5]

    property p_load; // [R7]
        @(posedge sys_clk) disable iff (reset)
        (cur.state == brap_pkg::brap_wait_addr && addr_valid && !stop_cond && !xfer_end)
            |=> ptr_addr == $past(addr_byte) && !read_valid;
    endproperty
    a_load: assert property (p_load) else $error("start address not loaded"); // [R7]

    property p_reserved; // [R6]
        @(posedge sys_clk) disable iff (reset)
        (burst_active && byte_req && ptr_addr == 8'h79 && !stop_cond)
            |=> ptr_addr == 8'h79;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved slot stepped"); // [R6]

    sequence s_read_taken;
        (cur.state == brap_pkg::brap_single || cur.state == brap_pkg::brap_burst) && byte_req;
    endsequence
    property p_answer; // [R1]
        @(posedge sys_clk) disable iff (reset)
        s_read_taken |=> read_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("byte request not answered"); // [R1]

    // A data strobe must never appear without a byte request in the cycle before
    property p_no_stray; // [R1]
        @(posedge sys_clk) disable iff (reset)
        read_valid |-> $past(byte_req);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("read strobe without request"); // [R1]

    property p_single_data; // [R1]
        @(posedge sys_clk) disable iff (reset)
        (cur.state == brap_pkg::brap_single && byte_req && ptr_addr != `BRAP_ADDR_STATUS)
            |=> read_data == $past(reg_rdata);
    endproperty
    a_single_data: assert property (p_single_data) else $error("single read data wrong"); // [R1]

    // End of select keeps the place, so the next SPI burst must be explicit
    property p_end_keep; // [R3]
        @(posedge sys_clk) disable iff (reset)
        (xfer_end && spi_sync && !byte_req && !stop_cond && !addr_valid)
            |=> ptr_addr == $past(ptr_addr) && !burst_active;
    endproperty
    a_end_keep: assert property (p_end_keep) else $error("select release moved pointer"); // [R3]

    sequence s_burst_any;
        burst_active && byte_req && !stop_cond &&
            ptr_addr != `BRAP_ADDR_RESERVED;
    endsequence
    property p_burst_any; // [R1]
        @(posedge sys_clk) disable iff (reset)
        s_burst_any |=> ptr_addr == $past(ptr_addr) + 8'h01;
    endproperty
    a_burst_any: assert property (p_burst_any) else $error("burst skipped a step"); // [R1]

    property p_start; // [R7]
        @(posedge sys_clk) disable iff (reset)
        (cur.state == brap_pkg::brap_idle && xfer_start && !stop_cond && !xfer_end)
            |=> cur.state == brap_pkg::brap_wait_addr && !read_valid;
    endproperty
    a_start: assert property (p_start) else $error("start did not await address"); // [R7]
endmodule : brap_pointer

// ===== bench/brap_host.sv
// Host controller model driving the front end events
`timescale 1ns/1ns
module brap_host (
    // Clock input
    input wire logic sys_clk,
    // Front end events
    output logic xfer_start,
    output logic addr_valid,
    output logic [7:0] addr_byte,
    output logic burst_read,
    output logic byte_req,
    output logic stop_cond,
    output logic xfer_end
);
    initial begin
        {xfer_start, addr_valid, burst_read, byte_req, stop_cond, xfer_end} = 6'h00;
        addr_byte = 8'hA5;
    end

    // Start address always sent first; SPI ends on select release, I2C on stop
    task automatic xfer(input logic [7:0] a, input logic b, input int n, input logic spi);
        @(posedge sys_clk);
        xfer_start <= 1'b1;
        @(posedge sys_clk);
        xfer_start <= 1'b0;
        addr_valid <= 1'b1;
        addr_byte <= a;
        burst_read <= b;
        @(posedge sys_clk);
        addr_valid <= 1'b0;
        addr_byte <= ~a; // Released lines must not keep the old value
        repeat (n) begin
            byte_req <= 1'b1;
            @(posedge sys_clk);
        end
        byte_req <= 1'b0;
        stop_cond <= !spi;
        xfer_end <= spi;
        @(posedge sys_clk);
        stop_cond <= spi; // Stray stop in SPI must not move the pointer
        xfer_end <= 1'b0;
        @(posedge sys_clk);
        stop_cond <= 1'b0;
    endtask : xfer
endmodule : brap_host

// ===== bench/testbench.sv
// Self-checking bench for the burst read address pointer
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic spi_mode = 1'b0;
    logic [1:0] fifo_mode = 2'h0;
    logic [7:0] sample_ready_flags = 8'h00;
    logic [7:0] fifo_flags = 8'h00;
    logic xfer_start, addr_valid, burst_read, byte_req, stop_cond, xfer_end;
    logic [7:0] addr_byte, reg_addr, read_data, ptr_addr;
    logic read_valid, burst_active;
    logic exp_burst = 1'b0;
    logic [7:0] exp_q[$];
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'hacb5;

    always #5 sys_clk = ~sys_clk;

    brap_pointer uut (.sys_clk(sys_clk), .reset(reset), .spi_mode(spi_mode),
        .xfer_start(xfer_start), .addr_valid(addr_valid), .addr_byte(addr_byte),
        .burst_read(burst_read), .byte_req(byte_req), .stop_cond(stop_cond),
        .xfer_end(xfer_end), .fifo_mode(fifo_mode), .sample_ready_flags(sample_ready_flags),
        .fifo_flags(fifo_flags), .reg_rdata(reg_addr ^ 8'h5A), .reg_addr(reg_addr),
        .read_data(read_data), .read_valid(read_valid), .ptr_addr(ptr_addr),
        .burst_active(burst_active));

    brap_host host (.sys_clk(sys_clk), .xfer_start(xfer_start), .addr_valid(addr_valid),
        .addr_byte(addr_byte), .burst_read(burst_read), .byte_req(byte_req),
        .stop_cond(stop_cond), .xfer_end(xfer_end));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("Checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // Register file stand-in answers address xor 5A; 0x00 is the alias
    function automatic logic [7:0] view(input logic [7:0] ad);
        if (ad != 8'h00) return ad ^ 8'h5A;
        return (fifo_mode == 2'h0) ? sample_ready_flags : fifo_flags;
    endfunction : view

    task automatic run(input logic [7:0] a, input logic b, input int n, input logic spi);
        logic [7:0] ad;
        ad = a;
        exp_burst = b;
        repeat (n) begin
            exp_q.push_back(view(ad));
            if (b && ad != 8'h79) ad++; // 0x79 has no successor
        end
        host.xfer(a, b, n, spi);
        #1;
        check("ptr_addr", ptr_addr, spi ? ad : 8'h00);
    endtask : run

    always @(posedge sys_clk) begin
        if (read_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("read_valid", 8'h01, 8'h00);
            end else begin
                check("read_data", read_data, exp_q.pop_front());
                check("burst_active", {7'h00, burst_active}, {7'h00, exp_burst});
            end
        end
        cycles++;
        if (cycles > 2000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("ptr_reset", ptr_addr, 8'h00);
        check("data_reset", read_data, 8'h00);
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            fifo_mode <= m[1:0];
            sample_ready_flags <= 8'($random(seed));
            fifo_flags <= 8'($random(seed));
            repeat (2) @(posedge sys_clk);
            run(8'h00, 1'b1, 3, 1'b0);
        end
        run(8'h70, 1'b0, 2, 1'b0);
        run(8'h77, 1'b1, 4, 1'b0);
        spi_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        run(8'h68, 1'b1, 2, 1'b1);
        run(8'h10, 1'b1, 1, 1'b1);
        repeat (3) @(posedge sys_clk);
        check("queue_left", 8'(exp_q.size()), 8'h00);
        // Reset while idle between transfers, then a fresh SPI burst from an explicit start
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("ptr_rerun", ptr_addr, 8'h00);
        check("burst_rerun", {7'h00, burst_active}, 8'h00);
        run(8'h05, 1'b1, 2, 1'b1);
        repeat (3) @(posedge sys_clk);
        check("queue_end", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule : testbench
